/* File: core/usr_rx.sv */
// synchronous slave serial receiver with an axi4-lite register slave
module usr_rx (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // axi4-lite write address and data
  input wire logic [11:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  // axi4-lite write response
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read
  input wire logic [11:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // serial link pins: clock and data, both two-way
  input wire usr_pkg::usr_link_type i_link,
  output usr_pkg::usr_link_type o_link,
  output usr_pkg::usr_link_type o_link_oe,
  // core sleep and interrupt
  input wire logic i_core_sleep,
  output logic o_wake,
  output logic o_core_irq,
  output logic [12:0] o_irq_vector,
  output logic o_irq
);
  import usr_pkg::*;

  // ==========================================================
  // register state
  logic [7:0] int_ctrl_q; // interrupt_control
  logic [7:0] pflags_q; // peripheral_flags_one, bit 5 owned by hardware
  logic [7:0] rx_ctrl_q; // control half of receive_status_control
  logic overrun_error_flag_q; // overrun_error_flag
  usr_word_type rx_buf_q; // receive_buffer plus received_ninth_bit
  logic [7:0] penables_q; // peripheral_enables_one
  logic [7:0] tx_ctrl_q; // transmit_status_control
  logic [7:0] baud_q; // baud_divisor, kept for software only
  logic [1:0] evt_stat_q; // sticky event status
  logic [1:0] evt_en_q; // event enables

  // bus handshake state
  logic aw_held_q; // write address captured
  logic w_held_q; // write data captured
  logic [9:0] waddr_q; // captured word index
  logic [31:0] wdata_q; // captured write data
  logic wlane_q; // lane 0 strobe captured
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;

  // link sampling
  logic [1:0] ck_sync_q; // bit 0 first stage, bit 1 second stage
  logic [1:0] dt_sync_q;
  logic ck_prev_q; // last settled clock level for edge finding
  logic [8:0] shift_q; // receive_shift_register
  logic [3:0] bit_cnt_q; // bits taken in the current word

  // derived strobes
  logic wr_go; // a write is carried out this cycle
  logic rd_go; // a read is taken this cycle
  logic [9:0] rd_idx;
  logic rx_active; // receiver allowed to shift
  logic ck_fall; // falling edge of the master's clock
  logic [3:0] word_len;
  logic word_done; // last bit of a word taken this cycle
  logic buf_read; // software reads the receive buffer
  logic receive_complete_flag; // receive_complete_flag
  logic continuous_receive_enable_clear; // software clears continuous enable

  // ==========================================================
  // link pins: slave never drives the shift clock or data line
  assign o_link = '{ck: 1'b0, dt: 1'b0};
  assign o_link_oe = '{ck: 1'b0, dt: 1'b0};

  // ==========================================================
  // axi4-lite write channel
  assign o_awready = ~aw_held_q;
  assign o_wready = ~w_held_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  // both halves present and no response waiting
  assign wr_go = aw_held_q & w_held_q & ~bvalid_q;

  // capture address and data independently, in either order
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= '0;
      wlane_q <= 1'b0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held_q <= 1'b1;
        waddr_q <= i_awaddr[11:2];
      end else if (wr_go) begin
        aw_held_q <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= i_wdata;
        wlane_q <= i_wstrb[0];
      end else if (wr_go) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // write response, error for an index that holds nothing
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      unique case (waddr_q)
        IDX_INT_CTRL, IDX_PFLAGS, IDX_RX_STAT, IDX_RX_BUF, IDX_PENABLES,
        IDX_TX_STAT, IDX_BAUD, IDX_EVT_STAT, IDX_EVT_CLR, IDX_EVT_EN: begin
          bresp_q <= RESP_OKAY;
        end
        default: begin
          bresp_q <= RESP_SLVERR;
        end
      endcase
    end else if (i_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // software writes to plain control registers
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      int_ctrl_q <= RST_ZERO;
      penables_q <= RST_ZERO;
      tx_ctrl_q <= RST_TX_STAT;
      baud_q <= RST_ZERO;
      rx_ctrl_q <= RST_ZERO;
      evt_en_q <= '0;
    end else if (wr_go && wlane_q) begin
      unique case (waddr_q)
        IDX_INT_CTRL: begin
          int_ctrl_q <= wdata_q[7:0];
        end
        IDX_PENABLES: begin
          penables_q <= wdata_q[7:0];
        end
        IDX_TX_STAT: begin
          // unimplemented bit 3 never stored
          tx_ctrl_q <= (wdata_q[7:0] & TX_STAT_SW_MASK) | RST_TX_STAT;
        end
        IDX_BAUD: begin
          baud_q <= wdata_q[7:0];
        end
        IDX_RX_STAT: begin
          // single receive enable is stored but steers nothing
          rx_ctrl_q <= wdata_q[7:0] & RX_STAT_SW_MASK;
        end
        IDX_EVT_EN: begin
          evt_en_q <= wdata_q[1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // continuous enable falling by software write
  assign continuous_receive_enable_clear = wr_go && wlane_q && (waddr_q == IDX_RX_STAT)
                      && rx_ctrl_q[B_CONTINUOUS_RECEIVE_ENABLE] && !wdata_q[B_CONTINUOUS_RECEIVE_ENABLE];

  // ==========================================================
  // axi4-lite read channel
  assign o_arready = ~rvalid_q;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;
  assign rd_go = i_arvalid & ~rvalid_q;
  assign rd_idx = i_araddr[11:2];
  // reading the buffer releases the receive-complete flag
  assign buf_read = rd_go && (rd_idx == IDX_RX_BUF);

  // read data mux, registered at the address handshake
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
      unique case (rd_idx)
        IDX_INT_CTRL: begin
          rdata_q[7:0] <= int_ctrl_q;
        end
        IDX_PFLAGS: begin
          rdata_q[7:0] <= pflags_q;
        end
        IDX_RX_STAT: begin
          // framing errors cannot occur in synchronous mode, bit reads zero
          rdata_q[7:0] <= {rx_ctrl_q[7:3], 1'b0, overrun_error_flag_q, rx_buf_q.ninth};
        end
        IDX_RX_BUF: begin
          rdata_q[7:0] <= rx_buf_q.data;
        end
        IDX_PENABLES: begin
          rdata_q[7:0] <= penables_q;
        end
        IDX_TX_STAT: begin
          rdata_q[7:0] <= tx_ctrl_q & TX_STAT_SW_MASK | RST_TX_STAT;
        end
        IDX_BAUD: begin
          rdata_q[7:0] <= baud_q;
        end
        IDX_EVT_STAT: begin
          rdata_q[1:0] <= evt_stat_q;
        end
        IDX_EVT_CLR, IDX_EVT_EN: begin
          // clear register is write only and reads zero
          rdata_q[1:0] <= (rd_idx == IDX_EVT_EN) ? evt_en_q : 2'b00;
        end
        default: begin
          rresp_q <= RESP_SLVERR;
        end
      endcase
    end else if (i_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // link synchronisers, two stages before any logic looks
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ck_sync_q <= 2'b00;
      dt_sync_q <= 2'b00;
      ck_prev_q <= 1'b0;
    end else begin
      ck_sync_q <= {ck_sync_q[0], i_link.ck};
      dt_sync_q <= {dt_sync_q[0], i_link.dt};
      ck_prev_q <= ck_sync_q[1];
    end
  end

  // data is sampled on the falling clock edge, as in master receive
  assign ck_fall = ck_prev_q & ~ck_sync_q[1];
  // slave mode: synchronous, port on, external clock; sleep does not gate it
  assign rx_active = tx_ctrl_q[B_SYNC] & rx_ctrl_q[B_SERIAL_PORT_ENABLE] & ~tx_ctrl_q[B_CLOCK_SOURCE_SELECT]
                     & rx_ctrl_q[B_CONTINUOUS_RECEIVE_ENABLE];
  assign word_len = rx_ctrl_q[B_RX9] ? BITS_9 : BITS_8;
  assign word_done = rx_active && ck_fall && (bit_cnt_q == word_len - 4'h1);

  // ==========================================================
  // shift register: least significant bit arrives first
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      shift_q <= '0;
      bit_cnt_q <= '0;
    end else if (!rx_active) begin
      // a dropped enable abandons any partial word
      bit_cnt_q <= '0;
    end else if (ck_fall) begin
      // one bit per falling edge of the master clock
      shift_q <= {dt_sync_q[1], shift_q[8:1]};
      bit_cnt_q <= word_done ? 4'h0 : bit_cnt_q + 4'h1;
    end
  end

  // ==========================================================
  // receive buffer, flag and overrun
  assign receive_complete_flag = pflags_q[B_RECEIVE_COMPLETE_FLAG];

  // finished word moves to the buffer unless unread data waits there
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rx_buf_q <= '0;
    end else if (word_done && (!receive_complete_flag || buf_read)) begin
      // realign the word so bit 0 is the first bit taken
      if (rx_ctrl_q[B_RX9]) begin
        rx_buf_q <= '{ninth: dt_sync_q[1], data: shift_q[8:1]};
      end else begin
        rx_buf_q <= '{ninth: rx_buf_q.ninth, data: {dt_sync_q[1], shift_q[8:2]}};
      end
    end
  end

  // peripheral flags: hardware sets receive-complete, set beats the clear
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      pflags_q <= RST_ZERO;
    end else begin
      if (wr_go && wlane_q && (waddr_q == IDX_PFLAGS)) begin
        pflags_q <= (wdata_q[7:0] & PFLAGS_SW_MASK) | (pflags_q & ~PFLAGS_SW_MASK);
      end
      if (word_done && (!receive_complete_flag || buf_read)) begin
        pflags_q[B_RECEIVE_COMPLETE_FLAG] <= 1'b1;
      end else if (buf_read) begin
        pflags_q[B_RECEIVE_COMPLETE_FLAG] <= 1'b0;
      end
    end
  end

  // overrun: unread data kept, new word dropped, cleared with the enable
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      overrun_error_flag_q <= 1'b0;
    end else if (word_done && receive_complete_flag && !buf_read) begin
      overrun_error_flag_q <= 1'b1;
    end else if (continuous_receive_enable_clear) begin
      overrun_error_flag_q <= 1'b0;
    end
  end

  // ==========================================================
  // event status: sticky, write-one clear, set wins over clear
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      evt_stat_q <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == EVT_WORD) ? (word_done && (!receive_complete_flag || buf_read))
                            : (word_done && receive_complete_flag && !buf_read)) begin
          evt_stat_q[i] <= 1'b1;
        end else if (wr_go && wlane_q && (waddr_q == IDX_EVT_CLR) && wdata_q[i]) begin
          evt_stat_q[i] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // core interrupt, wake and vector
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_wake <= 1'b0;
      o_core_irq <= 1'b0;
      o_irq_vector <= '0;
      o_irq <= 1'b0;
    end else begin
      // flag and enable wake a sleeping core even without global enable
      o_wake <= i_core_sleep & receive_complete_flag & penables_q[B_RECEIVE_COMPLETE_FLAG];
      o_core_irq <= receive_complete_flag & penables_q[B_RECEIVE_COMPLETE_FLAG] & int_ctrl_q[B_PERIPHERAL_INTERRUPT_ENABLE] & int_ctrl_q[B_GIE];
      // branch target presented once the core is interrupted
      if (receive_complete_flag && penables_q[B_RECEIVE_COMPLETE_FLAG] && int_ctrl_q[B_GIE] && int_ctrl_q[B_PERIPHERAL_INTERRUPT_ENABLE]) begin
        o_irq_vector <= IRQ_VECTOR;
      end else begin
        o_irq_vector <= '0;
      end
      o_irq <= |(evt_stat_q & evt_en_q);
    end
  end

endmodule

/* File: core/usr_pkg.sv */
// shared constants and types for the synchronous slave serial receiver
package usr_pkg;
  // ==========================================================
  // register indexes (byte address is four times the index)
  localparam logic [9:0] IDX_INT_CTRL = 10'h00B; // interrupt_control
  localparam logic [9:0] IDX_PFLAGS = 10'h00C; // peripheral_flags_one
  localparam logic [9:0] IDX_RX_STAT = 10'h018; // receive_status_control
  localparam logic [9:0] IDX_RX_BUF = 10'h01A; // receive_buffer
  localparam logic [9:0] IDX_PENABLES = 10'h08C; // peripheral_enables_one
  localparam logic [9:0] IDX_TX_STAT = 10'h098; // transmit_status_control
  localparam logic [9:0] IDX_BAUD = 10'h099; // baud_divisor
  localparam logic [9:0] IDX_EVT_STAT = 10'h100; // event status, read only
  localparam logic [9:0] IDX_EVT_CLR = 10'h101; // event clear, write only
  localparam logic [9:0] IDX_EVT_EN = 10'h102; // event enable
  // ==========================================================
  // field positions
  localparam int B_GIE = 7; // global_interrupt_enable
  localparam int B_PERIPHERAL_INTERRUPT_ENABLE = 6; // peripheral_interrupt_enable
  localparam int B_RECEIVE_COMPLETE_FLAG = 5; // receive_complete_flag / receive_interrupt_enable
  localparam int B_SERIAL_PORT_ENABLE = 7; // serial_port_enable
  localparam int B_RX9 = 6; // nine_bit_receive_select
  localparam int B_CONTINUOUS_RECEIVE_ENABLE = 4; // continuous_receive_enable
  localparam int B_FRAMING_ERROR_FLAG = 2; // framing_error_flag
  localparam int B_OVERRUN_ERROR_FLAG = 1; // overrun_error_flag
  localparam int B_RECEIVED_NINTH_BIT = 0; // received_ninth_bit
  localparam int B_CLOCK_SOURCE_SELECT = 7; // clock_source_select
  localparam int B_SYNC = 4; // synchronous mode select
  localparam int B_TRANSMIT_SHIFT_EMPTY = 1; // transmit_shift_empty
  localparam int EVT_WORD = 0; // event: word received
  localparam int EVT_OVR = 1; // event: overrun
  // ==========================================================
  // values after reset and fixed values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_TX_STAT = 8'h02;
  localparam logic [7:0] PFLAGS_SW_MASK = 8'hDF; // all flag bits but receive-complete
  localparam logic [7:0] RX_STAT_SW_MASK = 8'hF8; // control bits only
  localparam logic [7:0] TX_STAT_SW_MASK = 8'hF5; // bit 3 unimplemented, bit 1 status
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ==========================================================
  // a finished word as handed from the shifter to the buffer
  typedef struct packed {
    logic ninth; // ninth data bit
    logic [7:0] data; // low eight bits
  } usr_word_type;
  // pins of the serial link
  typedef struct packed {
    logic ck; // shift clock from the master
    logic dt; // data line
  } usr_link_type;
endpackage

/* File: test/usr_rx_monitor.sv */
// concurrent checks on the serial receiver ports
module usr_rx_monitor
  import usr_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // register bus
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic [11:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  // link pins and core side
  input wire usr_link_type o_link,
  input wire usr_link_type o_link_oe,
  input wire logic i_core_sleep,
  input wire logic o_wake,
  input wire logic o_core_irq,
  input wire logic [12:0] o_irq_vector
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // helpers
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  logic rd_bad; // read index outside the register map
  always_comb begin
    rd_bad = !(i_araddr[11:2] inside {IDX_INT_CTRL, IDX_PFLAGS, IDX_RX_STAT, IDX_RX_BUF,
      IDX_PENABLES, IDX_TX_STAT, IDX_BAUD, IDX_EVT_STAT, IDX_EVT_CLR, IDX_EVT_EN});
  end
  sequence wr_taken; // address and data taken on the same edge
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence rd_taken;
    i_arvalid && o_arready;
  endsequence
  // ==========================================================
  // properties
  chk_write_answer: assert property (wr_taken |-> ##[1:3] o_bvalid)
    else $error("write response late");
  chk_read_answer: assert property (rd_taken |=> o_rvalid)
    else $error("read response late");
  chk_read_unmapped: assert property (rd_taken and rd_bad |=>
    o_rresp == RESP_SLVERR && o_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  chk_upper_zero: assert property (o_rvalid |-> o_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  chk_link_released: assert property (o_link_oe == 2'h0 && o_link == 2'h0)
    else $error("link pin driven");
  chk_wake_sleep: assert property ($rose(o_wake) |-> $past(i_core_sleep))
    else $error("wake without sleep");
  chk_wake_ends: assert property (o_wake && !i_core_sleep |=> !o_wake)
    else $error("wake held after sleep ended");
  chk_vector_match: assert property (
    o_irq_vector == (o_core_irq ? IRQ_VECTOR : 13'h0000))
    else $error("vector does not follow interrupt");
  chk_irq_wakes: assert property (o_core_irq && $past(i_core_sleep) |-> o_wake)
    else $error("sleeping core not woken");
endmodule
bind usr_rx usr_rx_monitor u_mon (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_awvalid(i_awvalid),
  .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid),
  .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rvalid(o_rvalid),
  .o_rdata(o_rdata), .o_rresp(o_rresp), .o_link(o_link), .o_link_oe(o_link_oe),
  .i_core_sleep(i_core_sleep), .o_wake(o_wake), .o_core_irq(o_core_irq),
  .o_irq_vector(o_irq_vector));

/* File: test/usr_link_master.sv */
// partner model: external synchronous master driving shift clock and data
module usr_link_master
  import usr_pkg::*;
(
  // pins as driven by the master
  output usr_link_type o_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // clock stands low outside frames
  initial o_pin = 2'h0;
  // one word, lsb first, one bit per 800 ns clock period
  task automatic send(input logic [8:0] w, input int n);
    #13; // phase unrelated to the core clock
    for (int i = 0; i < n; i++) begin
      o_pin.ck = 1'b1;
      o_pin.dt = w[i];
      #400;
      o_pin.ck = 1'b0; // receiver samples on this fall
      #400; // data held through the low half
    end
    o_pin.dt = ~o_pin.dt; // data inverted after the last bit: no stale value
  endtask
endmodule

/* File: test/usr_rx_tb.sv */
// self-checking bench for the synchronous slave receiver
module usr_rx_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import usr_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic i_mclk = 1'b0, i_rst_n = 1'b0, sleep = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic awready, wready, bvalid, arready, rvalid, wake, core_irq, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [12:0] vec;
  usr_link_type link_o, link_oe, m_pin, line;
  int comparisons = 0, miscompares = 0, cycles = 0;
  // pin level: whoever enables drives, else the master
  assign line = (link_oe & link_o) | (~link_oe & m_pin);
  always #50 i_mclk = ~i_mclk;
  usr_link_master u_master (.o_pin(m_pin));
  usr_rx u_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(1'b1), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(1'b1),
    .i_link(line), .o_link(link_o), .o_link_oe(link_oe), .i_core_sleep(sleep), .o_wake(wake),
    .o_core_irq(core_irq), .o_irq_vector(vec), .o_irq(irq));
  // ==========================================================
  // checking and closing
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard: the run needs a little under a thousand cycles
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 10000) begin
      miscompares++;
      finish_test();
    end
  end
  // expected status: control bits kept, overrun and ninth bit from hardware
  function automatic logic [31:0] stat_exp(input logic [7:0] c, input logic ov, input logic n9);
    return {24'h00_0000, (c & RX_STAT_SW_MASK) | {6'h00, ov, n9}};
  endfunction
  // ==========================================================
  // bus master tasks: both channels offered together, held until taken
  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    logic pa, pw, got;
    pa = 1'b1;
    pw = 1'b1;
    got = 1'b0;
    awaddr <= {a, 2'b00};
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (pa || pw) begin
      @(negedge i_mclk);
      if (awready === 1'b1) pa = 1'b0;
      if (wready === 1'b1) pw = 1'b0;
      @(posedge i_mclk);
      if (!pa) awvalid <= 1'b0;
      if (!pw) wvalid <= 1'b0;
    end
    while (!got) begin
      @(negedge i_mclk);
      // an unknown answer must keep waiting, never end the wait
      got = (bvalid === 1'b1);
      if (got) chk("write response", er, bresp);
      @(posedge i_mclk);
    end
  endtask
  task automatic rdc(input string n, input logic [9:0] a, input logic [31:0] e,
                     input logic [1:0] er = RESP_OKAY);
    logic got;
    logic [31:0] d;
    logic [1:0] r;
    araddr <= {a, 2'b00};
    arvalid <= 1'b1;
    do begin
      @(negedge i_mclk);
      got = (arready === 1'b1);
      @(posedge i_mclk);
    end while (!got);
    arvalid <= 1'b0;
    // data and response are taken while rvalid stands, before the edge that ends it
    do begin
      @(negedge i_mclk);
      got = (rvalid === 1'b1);
      d = rdata;
      r = rresp;
      @(posedge i_mclk);
    end while (!got);
    chk(n, e, d);
    chk("read response", er, r);
  endtask
  // one word from the master, then the core-side lines once settled
  task automatic xfer(input logic [8:0] w, input int n, input logic ei, input logic ew);
    u_master.send(w, n);
    repeat (8) @(posedge i_mclk);
    @(negedge i_mclk);
    chk("core irq", ei, core_irq);
    chk("vector", ei ? IRQ_VECTOR : 13'h0000, vec);
    chk("wake", ew, wake);
    @(posedge i_mclk);
  endtask
  task automatic irq_is(input logic e);
    @(negedge i_mclk);
    chk("irq line", e, irq);
    @(posedge i_mclk);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    logic [9:0] ri [7];
    logic [7:0] ctrl;
    logic [8:0] w, w2;
    logic n9;
    ri = '{IDX_INT_CTRL, IDX_PFLAGS, IDX_RX_STAT, IDX_RX_BUF, IDX_PENABLES, IDX_TX_STAT, IDX_BAUD};
    n9 = 1'b0;
    void'($urandom(73427));
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rdc("reset value", ri[i], (ri[i] == IDX_TX_STAT) ? RST_TX_STAT : RST_ZERO);
    end
    rdc("unmapped", 10'h3FF, 32'h0000_0000, RESP_SLVERR);
    wr(10'h3FF, 8'h55, RESP_SLVERR);
    wr(IDX_TX_STAT, 8'hFF);
    rdc("tx status", IDX_TX_STAT, (8'hFF & TX_STAT_SW_MASK) | 8'h02);
    wr(IDX_TX_STAT, 8'h10); // synchronous, external clock
    wr(IDX_PENABLES, 8'h20); // parallel port bit kept clear
    wr(IDX_INT_CTRL, 8'hC0);
    wr(IDX_EVT_EN, 8'h01);
    // random words in both widths, single-receive bit random
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 3; k++) begin
        ctrl = 8'h90 | (m[0] ? 8'h40 : 8'h00) | (8'($urandom) & 8'h20);
        wr(IDX_RX_STAT, ctrl);
        w = 9'($urandom);
        xfer(w, m ? 9 : 8, 1'b1, 1'b0);
        irq_is(1'b1);
        wr(IDX_EVT_EN, 8'h00);
        irq_is(1'b0);
        wr(IDX_EVT_EN, 8'h01);
        irq_is(1'b1);
        wr(IDX_EVT_CLR, 8'h01);
        irq_is(1'b0);
        if (m) n9 = w[8];
        rdc("rx status", IDX_RX_STAT, stat_exp(ctrl, 1'b0, n9));
        rdc("rx buffer", IDX_RX_BUF, {24'h00_0000, w[7:0]});
        rdc("flags", IDX_PFLAGS, 32'h0000_0000);
      end
    end
    // overrun: second word lands on an unread buffer
    wr(IDX_RX_STAT, 8'h90);
    w = 9'($urandom);
    w2 = 9'($urandom);
    xfer(w, 8, 1'b1, 1'b0);
    xfer(w2, 8, 1'b1, 1'b0);
    rdc("overrun status", IDX_RX_STAT, stat_exp(8'h90, 1'b1, n9));
    rdc("kept buffer", IDX_RX_BUF, {24'h00_0000, w[7:0]});
    rdc("events", IDX_EVT_STAT, 32'h0000_0003);
    wr(IDX_EVT_CLR, 8'h03);
    // single receive left on alone: a slave must still take nothing
    wr(IDX_RX_STAT, 8'hA0);
    rdc("cleared status", IDX_RX_STAT, stat_exp(8'hA0, 1'b0, n9));
    xfer(9'($urandom), 8, 1'b0, 1'b0);
    rdc("idle events", IDX_EVT_STAT, 32'h0000_0000);
    // word received in sleep wakes the core without global enable
    wr(IDX_RX_STAT, 8'h90);
    wr(IDX_INT_CTRL, 8'h00);
    sleep <= 1'b1;
    w = 9'($urandom);
    xfer(w, 8, 1'b0, 1'b1);
    wr(IDX_INT_CTRL, 8'hC0);
    @(negedge i_mclk);
    chk("sleep vector", IRQ_VECTOR, vec);
    @(posedge i_mclk);
    sleep <= 1'b0;
    rdc("sleep buffer", IDX_RX_BUF, {24'h00_0000, w[7:0]});
    finish_test();
  end
endmodule
